// ===== rtl/pwr_ctl_pkg.sv
// Constants and types for power-mode and reset control
// Notes on behaviour
// - Five operating states exist: normal, sleep, dead, stop and unpowered, each permitting its own functions.
// - With run/stop high and the supply at or above 4.5 V, power-save bit 1 selects normal operation and 0 selects sleep.
// - Sleep blocks new flash writes, halts flash reads and conversion, puts the regulator in low power and holds the outputs.
// - A main supply below 4.5 V blocks flash writes, stops conversion and regulator, and is flagged in status.
// - Power-on reset follows run/stop going low and a joint rise of supply and run/stop from unpowered.
// - Power-on reset clears control, flash and conversion state, outputs, port and result registers, CRC and address.
// - Power-on reset sets status bit 9 to tell software a reset occurred.
// - A port write reaches the output pins about 1.0 us after the closing stop condition.
// - An eight-byte flash write takes typically 53.0 ms and the address is acknowledged again only once it completes or is aborted.
// - A conversion takes one voltage channel and the current channel at 10 bits and flags its end after 80 ms.
// - The output pins follow the port register written by the host.
package pwr_ctl_pkg;
   localparam int unsigned CLK_HZ = 20_000_000;
   localparam int unsigned POR_TIME_NS = 20_000;
   localparam int unsigned MODE_SHIFT_NS = 12_000;
   localparam int unsigned PORT_DELAY_NS = 1_000;
   localparam int unsigned FLASH_WRITE_US = 53_000;
   localparam int unsigned ADC_CONV_US = 80_000;
   localparam int unsigned CLK_NS = 1_000_000_000 / CLK_HZ;
   localparam int unsigned POR_CYC = (POR_TIME_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned MODE_SHIFT_CYC = (MODE_SHIFT_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned PORT_DELAY_CYC = PORT_DELAY_NS / CLK_NS;
   localparam int unsigned FLASH_WRITE_CYC = FLASH_WRITE_US * (CLK_HZ / 1_000_000);
   localparam int unsigned ADC_CONV_CYC = ADC_CONV_US * (CLK_HZ / 1_000_000);
   localparam int CNT_W = 24;
   localparam int PORT_W = 4;
   localparam int ADC_W = 10;
   localparam int ADDR_W = 8;
   localparam int STAT_W = 16;
   localparam int STAT_SAVE_BIT = 0;
   localparam int STAT_DEAD_BIT = 1;
   localparam int STAT_POR_BIT = 9;
   localparam logic [ADDR_W-1:0] ADDR_RST = 8'h00;
   localparam logic [PORT_W-1:0] PORT_RST = 4'h0;
   localparam logic [ADC_W-1:0] ADC_RST = 10'h000;
   localparam logic [7:0] CRC_RST = 8'h00;
   typedef enum logic [2:0]
   {
      MODE_NORMAL = 3'b000,
      MODE_SLEEP = 3'b001,
      MODE_DEAD = 3'b010,
      MODE_STOP = 3'b011,
      MODE_UNPOWERED = 3'b100
   } pwr_mode_e;
endpackage

// ===== rtl/delay_timer.sv
// One-shot cycle timer with done pulse
`timescale 1ns/1ps
module delay_timer
   import pwr_ctl_pkg::*;
(
   input wire logic sys_clk_in, // Clock
   input wire logic rst_n_in, // Async reset
   input wire logic clear_in, // Abort and idle
   input wire logic start_in, // Load count
   input wire logic [CNT_W-1:0] count_in, // Cycles to run
   output logic busy_out, // Running
   output logic done_out // One-cycle end pulse
);
   logic [CNT_W-1:0] cnt_r, cnt_nxt;
   logic busy_r, busy_nxt, done_r, done_nxt;
   always_comb
   begin
      cnt_nxt = cnt_r;
      busy_nxt = busy_r;
      done_nxt = 1'b0;
      if (clear_in)
      begin
         busy_nxt = 1'b0;
         cnt_nxt = '0;
      end
      else if (start_in)
      begin
         busy_nxt = 1'b1;
         cnt_nxt = count_in;
      end
      else if (busy_r)
      begin
         if (cnt_r <= 24'h000001)
         begin
            busy_nxt = 1'b0;
            done_nxt = 1'b1;
         end
         else
            cnt_nxt = cnt_r - 24'h000001;
      end
   end
   always_ff @(posedge sys_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         cnt_r <= '0;
         busy_r <= 1'b0;
         done_r <= 1'b0;
      end
      else
      begin
         cnt_r <= cnt_nxt;
         busy_r <= busy_nxt;
         done_r <= done_nxt;
      end
   end
   assign busy_out = busy_r;
   assign done_out = done_r;
endmodule // delay_timer

// ===== rtl/por_gen.sv
// Power-on reset pulse generator
`timescale 1ns/1ps
module por_gen
   import pwr_ctl_pkg::*;
(
   input wire logic sys_clk_in, // Clock
   input wire logic rst_n_in, // Async reset
   input wire logic run_stop_input_in, // Run/stop pin level
   output logic por_active_out, // Reset period in progress
   output logic por_pulse_out // One cycle at reset start
);
   logic run_q_r, run_q_nxt;
   logic [CNT_W-1:0] cnt_r, cnt_nxt;
   logic pulse_r, pulse_nxt;
   always_comb
   begin
      run_q_nxt = run_stop_input_in;
      pulse_nxt = 1'b0;
      cnt_nxt = cnt_r;
      if (!run_stop_input_in)
         cnt_nxt = CNT_W'(POR_CYC);
      else if (!run_q_r)
      begin
         pulse_nxt = 1'b1;
         cnt_nxt = CNT_W'(POR_CYC);
      end
      else if (cnt_r != '0)
         cnt_nxt = cnt_r - 24'h000001;
   end
   always_ff @(posedge sys_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         run_q_r <= 1'b0;
         cnt_r <= CNT_W'(POR_CYC);
         pulse_r <= 1'b1;
      end
      else
      begin
         run_q_r <= run_q_nxt;
         cnt_r <= cnt_nxt;
         pulse_r <= pulse_nxt;
      end
   end
   assign por_active_out = (cnt_r != '0) || !run_stop_input_in;
   assign por_pulse_out = pulse_r;
endmodule // por_gen

// ===== rtl/pwr_mode_ctl.sv
// Power-mode, reset effects and operation timing control
`timescale 1ns/1ps
module pwr_mode_ctl
   import pwr_ctl_pkg::*;
(
   input wire logic sys_clk_in, // 20 MHz clock
   input wire logic rst_n_in, // Async reset, active low
   input wire logic run_stop_input_in, // Run/stop pin
   input wire logic main_supply_ok_in, // Supply at or above 4.5 V
   input wire logic stop_cond_in, // Stop condition pulse
   input wire logic save_wr_in, // Power-save write, at stop
   input wire logic save_val_in, // Power-save value
   input wire logic port_wr_in, // Port write, at stop
   input wire logic [PORT_W-1:0] port_val_in, // Port data
   input wire logic flash_wr_req_in, // 8-byte write, at stop
   input wire logic adc_req_in, // Conversion, at stop
   input wire logic [1:0] adc_chan_in, // Voltage channel
   input wire logic [ADC_W-1:0] adc_volt_in, // Voltage sample
   input wire logic [ADC_W-1:0] adc_curr_in, // Current sample
   input wire logic [ADDR_W-1:0] addr_wr_in, // Address register load
   input wire logic addr_load_in, // Address load strobe
   input wire logic [7:0] crc_in, // CRC next value
   input wire logic crc_load_in, // CRC load strobe
   input wire logic por_flag_clr_in, // Clear reset flag
   output logic [PORT_W-1:0] general_output_pins_out, // Port pins
   output logic [2:0] mode_out, // Current mode code
   output logic reg_normal_out, // Regulator full power
   output logic reg_low_power_out, // Regulator low power
   output logic flash_wr_en_out, // Flash write allowed
   output logic flash_rd_en_out, // Flash read allowed
   output logic adc_en_out, // Conversion allowed
   output logic flash_busy_out, // Flash write in progress
   output logic addr_ack_en_out, // Slave address may be acked
   output logic bus_hold_off_out, // Reset or mode shift period
   output logic adc_end_out, // Conversion-end flag
   output logic [1:0] adc_chan_out, // Converted channel
   output logic [ADC_W-1:0] adc_volt_out, // Voltage result
   output logic [ADC_W-1:0] adc_curr_out, // Current result
   output logic [STAT_W-1:0] power_status_out, // Power status word
   output logic [ADDR_W-1:0] addr_out, // Internal address
   output logic [7:0] crc_out // CRC state
);
   logic por_active, por_pulse;
   logic ft_busy, ft_done, at_busy, at_done, pt_done, mt_busy;
   logic save_r, save_nxt, por_flag_r, por_flag_nxt;
   logic [PORT_W-1:0] port_r, port_nxt, pin_r, pin_nxt, pend_r, pend_nxt;
   logic adc_end_r, adc_end_nxt;
   logic [1:0] chan_r, chan_nxt, chan_q_r, chan_q_nxt;
   logic [ADC_W-1:0] volt_r, volt_nxt, curr_r, curr_nxt;
   logic [ADDR_W-1:0] addr_r, addr_nxt;
   logic [7:0] crc_r, crc_nxt;
   pwr_mode_e mode;
   logic normal, flash_go, adc_go, save_go, port_go, clr;

   por_gen u_por
   (
      .sys_clk_in(sys_clk_in),
      .rst_n_in(rst_n_in),
      .run_stop_input_in(run_stop_input_in),
      .por_active_out(por_active),
      .por_pulse_out(por_pulse)
   );

   always_comb
   begin
      if (!run_stop_input_in)
         mode = main_supply_ok_in ? MODE_STOP : MODE_UNPOWERED;
      else if (!main_supply_ok_in)
         mode = MODE_DEAD;
      else if (save_r)
         mode = MODE_NORMAL;
      else
         mode = MODE_SLEEP;
   end

   assign normal = (mode == MODE_NORMAL) && !mt_busy && !por_active;
   assign clr = por_pulse || !run_stop_input_in;
   assign flash_go = flash_wr_req_in && normal && !ft_busy;
   assign adc_go = adc_req_in && normal && !at_busy;
   assign save_go = save_wr_in && !por_active && (save_val_in != save_r);
   assign port_go = port_wr_in && (mode == MODE_NORMAL);

   delay_timer u_flash_tmr
   (
      .sys_clk_in(sys_clk_in),
      .rst_n_in(rst_n_in),
      .clear_in(clr || !main_supply_ok_in),
      .start_in(flash_go),
      .count_in(CNT_W'(FLASH_WRITE_CYC)),
      .busy_out(ft_busy),
      .done_out(ft_done)
   );
   delay_timer u_adc_tmr
   (
      .sys_clk_in(sys_clk_in),
      .rst_n_in(rst_n_in),
      .clear_in(clr || mode != MODE_NORMAL),
      .start_in(adc_go),
      .count_in(CNT_W'(ADC_CONV_CYC)),
      .busy_out(at_busy),
      .done_out(at_done)
   );
   delay_timer u_port_tmr
   (
      .sys_clk_in(sys_clk_in),
      .rst_n_in(rst_n_in),
      .clear_in(clr),
      .start_in(port_go),
      .count_in(CNT_W'(PORT_DELAY_CYC)),
      .busy_out(),
      .done_out(pt_done)
   );
   delay_timer u_mode_tmr
   (
      .sys_clk_in(sys_clk_in),
      .rst_n_in(rst_n_in),
      .clear_in(clr),
      .start_in(save_go),
      .count_in(CNT_W'(MODE_SHIFT_CYC)),
      .busy_out(mt_busy),
      .done_out()
   );

   always_comb
   begin
      save_nxt = save_r;
      por_flag_nxt = por_flag_r;
      port_nxt = port_r;
      pend_nxt = pend_r;
      pin_nxt = pin_r;
      adc_end_nxt = adc_end_r;
      chan_nxt = chan_r;
      chan_q_nxt = chan_q_r;
      volt_nxt = volt_r;
      curr_nxt = curr_r;
      addr_nxt = addr_r;
      crc_nxt = crc_r;
      if (clr)
      begin
         save_nxt = 1'b1;
         por_flag_nxt = 1'b1;
         port_nxt = PORT_RST;
         pend_nxt = PORT_RST;
         pin_nxt = PORT_RST;
         adc_end_nxt = 1'b0;
         chan_nxt = 2'h0;
         chan_q_nxt = 2'h0;
         volt_nxt = ADC_RST;
         curr_nxt = ADC_RST;
         addr_nxt = ADDR_RST;
         crc_nxt = CRC_RST;
      end
      else
      begin
         if (save_go)
            save_nxt = save_val_in;
         if (por_flag_clr_in)
            por_flag_nxt = 1'b0;
         if (port_go)
         begin
            port_nxt = port_val_in;
            pend_nxt = port_val_in;
         end
         if (pt_done)
            pin_nxt = pend_r;
         if (adc_go)
         begin
            adc_end_nxt = 1'b0;
            chan_q_nxt = adc_chan_in;
         end
         else if (at_done)
         begin
            adc_end_nxt = 1'b1;
            chan_nxt = chan_q_r;
            volt_nxt = adc_volt_in;
            curr_nxt = adc_curr_in;
         end
         if (addr_load_in)
            addr_nxt = addr_wr_in;
         if (crc_load_in)
            crc_nxt = crc_in;
      end
   end

   always_ff @(posedge sys_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         save_r <= 1'b1;
         por_flag_r <= 1'b1;
         port_r <= PORT_RST;
         pend_r <= PORT_RST;
         pin_r <= PORT_RST;
         adc_end_r <= 1'b0;
         chan_r <= 2'h0;
         chan_q_r <= 2'h0;
         volt_r <= ADC_RST;
         curr_r <= ADC_RST;
         addr_r <= ADDR_RST;
         crc_r <= CRC_RST;
      end
      else
      begin
         save_r <= save_nxt;
         por_flag_r <= por_flag_nxt;
         port_r <= port_nxt;
         pend_r <= pend_nxt;
         pin_r <= pin_nxt;
         adc_end_r <= adc_end_nxt;
         chan_r <= chan_nxt;
         chan_q_r <= chan_q_nxt;
         volt_r <= volt_nxt;
         curr_r <= curr_nxt;
         addr_r <= addr_nxt;
         crc_r <= crc_nxt;
      end
   end

   always_comb
   begin
      power_status_out = '0;
      power_status_out[STAT_SAVE_BIT] = save_r;
      power_status_out[STAT_DEAD_BIT] = !main_supply_ok_in;
      power_status_out[STAT_POR_BIT] = por_flag_r;
   end

   assign general_output_pins_out = pin_r;
   assign mode_out = mode;
   assign reg_normal_out = (mode == MODE_NORMAL);
   assign reg_low_power_out = (mode == MODE_SLEEP);
   assign flash_wr_en_out = normal;
   assign flash_rd_en_out = normal;
   assign adc_en_out = normal;
   assign flash_busy_out = ft_busy;
   assign addr_ack_en_out = !ft_busy && !por_active;
   assign bus_hold_off_out = por_active || mt_busy;
   assign adc_end_out = adc_end_r;
   assign adc_chan_out = chan_r;
   assign adc_volt_out = volt_r;
   assign adc_curr_out = curr_r;
   assign addr_out = addr_r;
   assign crc_out = crc_r;
endmodule // pwr_mode_ctl

// ===== tb/pwr_mode_ctl_assertions.sv
// Port assertions for the power-mode controller
`timescale 1ns/1ps
module pwr_mode_ctl_assertions
   import pwr_ctl_pkg::*;
(
   input wire logic sys_clk_in, // Clock
   input wire logic rst_n_in, // Reset
   input wire logic run_stop_input_in, // Run/stop
   input wire logic main_supply_ok_in, // Supply ok
   input wire logic port_wr_in, // Port write
   input wire logic [PORT_W-1:0] port_val_in, // Port data
   input wire logic flash_wr_req_in, // Flash request
   input wire logic [PORT_W-1:0] general_output_pins_out, // Pins
   input wire logic [2:0] mode_out, // Mode
   input wire logic flash_wr_en_out, // Write allowed
   input wire logic flash_busy_out, // Flash busy
   input wire logic addr_ack_en_out, // Ack allowed
   input wire logic bus_hold_off_out, // Hold-off
   input wire logic [STAT_W-1:0] power_status_out // Status
);
   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (!rst_n_in);
   port_delay_a: assert property (
      port_wr_in && mode_out == MODE_NORMAL |->
      ##22 general_output_pins_out == $past(port_val_in, 22)) else $error("pins late");
   stop_clear_a: assert property (
      !run_stop_input_in |=> general_output_pins_out == 4'h0) else $error("pins kept");
   dead_mode_a: assert property (
      run_stop_input_in && !main_supply_ok_in |-> mode_out == MODE_DEAD
      && !flash_wr_en_out && power_status_out[STAT_DEAD_BIT]) else $error("dead mode");
   sleep_func_a: assert property (
      mode_out == MODE_SLEEP |-> !flash_wr_en_out) else $error("sleep write");
   save_mode_a: assert property (
      run_stop_input_in && main_supply_ok_in |->
      mode_out == (power_status_out[STAT_SAVE_BIT] ? MODE_NORMAL : MODE_SLEEP))
      else $error("save mode");
   por_flag_a: assert property (
      $rose(run_stop_input_in) |-> ##[1:3] power_status_out[STAT_POR_BIT]) else $error("flag");
   hold_off_a: assert property (
      $rose(run_stop_input_in) |=> bus_hold_off_out[*8]) else $error("hold");
   ack_block_a: assert property (
      flash_busy_out |-> !addr_ack_en_out) else $error("ack busy");
   flash_cause_a: assert property (
      $rose(flash_busy_out) |-> $past(flash_wr_req_in)) else $error("busy cause");
   dead_abort_a: assert property (
      flash_busy_out && !main_supply_ok_in |=> !flash_busy_out) else $error("abort");
   sleep_c: cover property (mode_out == MODE_SLEEP);
   flash_c: cover property ($rose(flash_busy_out));
   stop_c: cover property (mode_out == MODE_STOP);
endmodule // pwr_mode_ctl_assertions
bind pwr_mode_ctl pwr_mode_ctl_assertions chk (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
   .run_stop_input_in(run_stop_input_in), .main_supply_ok_in(main_supply_ok_in),
   .port_wr_in(port_wr_in), .port_val_in(port_val_in), .flash_wr_req_in(flash_wr_req_in),
   .general_output_pins_out(general_output_pins_out), .mode_out(mode_out),
   .flash_wr_en_out(flash_wr_en_out), .flash_busy_out(flash_busy_out),
   .addr_ack_en_out(addr_ack_en_out), .bus_hold_off_out(bus_hold_off_out),
   .power_status_out(power_status_out));

// ===== tb/pwr_host_model.sv
// Host requester that keeps off the bus during hold-off
`timescale 1ns/1ps
module pwr_host_model
   import pwr_ctl_pkg::*;
(
   input wire logic sys_clk_in, // Clock
   input wire logic bus_hold_off_in, // Hold-off
   output logic stop_cond_out, // Stop condition
   output logic port_wr_out, // Port write
   output logic save_wr_out, // Save write
   output logic flash_wr_req_out, // Flash request
   output logic adc_req_out, // Conversion request
   output logic [PORT_W-1:0] val_out, // Write data
   output logic late_out // Hold-off too long
);
   initial
   begin
      {stop_cond_out, adc_req_out, flash_wr_req_out, save_wr_out, port_wr_out} = 5'h00;
      val_out = 4'h0;
      late_out = 1'b0;
   end
   // Kind 0 port, 1 save, 2 flash, 3 conversion; call at a falling edge
   task automatic send(input int kind, input logic [PORT_W-1:0] val);
      int n;
      @(negedge sys_clk_in);
      n = 0;
      while (bus_hold_off_in !== 1'b0 && n < 1000)
      begin
         @(negedge sys_clk_in);
         n++;
      end
      late_out = late_out | (n >= 1000);
      val_out = val;
      {adc_req_out, flash_wr_req_out, save_wr_out, port_wr_out} = 4'h1 << kind;
      stop_cond_out = 1'b1;
      @(negedge sys_clk_in);
      {stop_cond_out, adc_req_out, flash_wr_req_out, save_wr_out, port_wr_out} = 5'h00;
      val_out = ~val;
   endtask
endmodule // pwr_host_model

// ===== tb/pwr_mode_ctl_tb.sv
// Self-checking bench for the power-mode controller
`timescale 1ns/1ps
module pwr_mode_ctl_tb
   import pwr_ctl_pkg::*;
;
   logic sys_clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic run_stop_input_in = 1'b1;
   logic main_supply_ok_in = 1'b1;
   logic addr_load_in = 1'b0;
   logic crc_load_in = 1'b0;
   logic por_flag_clr_in = 1'b0;
   logic stop_cond_in, port_wr_in, save_wr_in, flash_wr_req_in, adc_req_in, late;
   logic [PORT_W-1:0] val, general_output_pins_out;
   logic [2:0] mode_out;
   logic reg_normal_out, reg_low_power_out, flash_wr_en_out, flash_rd_en_out, adc_en_out;
   logic flash_busy_out, addr_ack_en_out, bus_hold_off_out, adc_end_out;
   logic [ADC_W-1:0] adc_volt_out, adc_curr_out;
   logic [1:0] adc_chan_out;
   logic [STAT_W-1:0] power_status_out;
   logic [7:0] addr_out, crc_out;
   int errors = 0;
   int tests_run = 0;
   int n;
   always #25 sys_clk_in = ~sys_clk_in;
   pwr_host_model host (.sys_clk_in(sys_clk_in), .bus_hold_off_in(bus_hold_off_out),
      .stop_cond_out(stop_cond_in), .port_wr_out(port_wr_in), .save_wr_out(save_wr_in),
      .flash_wr_req_out(flash_wr_req_in), .adc_req_out(adc_req_in), .val_out(val),
      .late_out(late));
   pwr_mode_ctl dut (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
      .run_stop_input_in(run_stop_input_in), .main_supply_ok_in(main_supply_ok_in),
      .stop_cond_in(stop_cond_in), .save_wr_in(save_wr_in), .save_val_in(val[0]),
      .port_wr_in(port_wr_in), .port_val_in(val), .flash_wr_req_in(flash_wr_req_in),
      .adc_req_in(adc_req_in), .adc_chan_in(val[1:0]), .adc_volt_in(10'h2A5),
      .adc_curr_in(10'h15A), .addr_wr_in(8'h5A), .addr_load_in(addr_load_in),
      .crc_in(8'hC3), .crc_load_in(crc_load_in), .por_flag_clr_in(por_flag_clr_in),
      .general_output_pins_out(general_output_pins_out), .mode_out(mode_out),
      .reg_normal_out(reg_normal_out), .reg_low_power_out(reg_low_power_out),
      .flash_wr_en_out(flash_wr_en_out), .flash_rd_en_out(flash_rd_en_out),
      .adc_en_out(adc_en_out), .flash_busy_out(flash_busy_out),
      .addr_ack_en_out(addr_ack_en_out), .bus_hold_off_out(bus_hold_off_out),
      .adc_end_out(adc_end_out), .adc_chan_out(adc_chan_out), .adc_volt_out(adc_volt_out),
      .adc_curr_out(adc_curr_out), .power_status_out(power_status_out), .addr_out(addr_out),
      .crc_out(crc_out));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic tick(input int k);
      repeat (k) @(negedge sys_clk_in);
   endtask
   // Cycles until the hold-off window closes
   task automatic hold_len();
      n = 0;
      while (bus_hold_off_out !== 1'b0 && n < 2000)
      begin
         tick(1);
         n++;
      end
      errors += (n == 2000);
      if (n == 2000)
         finish_test();
   endtask
   initial
   begin
      #200000;
      errors++;
      finish_test();
   end
   initial
   begin
      tick(8);
      rst_n_in = 1'b1;
      check({addr_out, crc_out, general_output_pins_out, adc_end_out}, 21'h0);
      check({adc_volt_out, power_status_out}, 26'h0000201);
      check({adc_chan_out, adc_curr_out}, 12'h000);
      hold_len();
      check(n >= POR_CYC - 1 && n <= POR_CYC + 1, 1'b1);
      $display("reset test done");
      host.send(0, 4'h5);
      n = 0;
      while (general_output_pins_out !== 4'h5 && n < 100)
      begin
         tick(1);
         n++;
      end
      check(n, PORT_DELAY_CYC + 1);
      $display("port test done");
      host.send(3, 4'h2);
      host.send(1, 4'h0);
      tick(1);
      check(mode_out, 3'h1);
      check({reg_normal_out, reg_low_power_out, flash_wr_en_out, flash_rd_en_out,
         adc_en_out, power_status_out[0]}, 6'b010000);
      hold_len();
      check(n, MODE_SHIFT_CYC - 1);
      host.send(0, 4'hF);
      host.send(2, 4'h0);
      tick(25);
      check({general_output_pins_out, flash_busy_out, adc_end_out}, 6'h14);
      $display("sleep test done");
      host.send(1, 4'h1);
      tick(1);
      check(mode_out, 3'h0);
      hold_len();
      check(n, MODE_SHIFT_CYC - 1);
      host.send(2, 4'h0);
      tick(1);
      check({flash_busy_out, addr_ack_en_out}, 2'b10);
      main_supply_ok_in = 1'b0;
      tick(2);
      check({mode_out, power_status_out[1], flash_wr_en_out, adc_en_out, flash_busy_out,
         reg_normal_out}, 8'h50);
      main_supply_ok_in = 1'b1;
      por_flag_clr_in = 1'b1;
      addr_load_in = 1'b1;
      crc_load_in = 1'b1;
      tick(1);
      {por_flag_clr_in, addr_load_in, crc_load_in} = 3'h0;
      tick(1);
      check({power_status_out, addr_out, crc_out}, 32'h00015AC3);
      $display("supply test done");
      run_stop_input_in = 1'b0;
      tick(2);
      check({mode_out, general_output_pins_out, addr_out, crc_out}, 23'h300000);
      main_supply_ok_in = 1'b0;
      tick(1);
      check(mode_out, 3'h4);
      main_supply_ok_in = 1'b1;
      run_stop_input_in = 1'b1;
      tick(1);
      check(power_status_out[STAT_POR_BIT], 1'b1);
      hold_len();
      check(n >= POR_CYC - 2 && n <= POR_CYC + 1, 1'b1);
      check(late, 1'b0);
      $display("stop test done");
      finish_test();
   end
endmodule // pwr_mode_ctl_tb
